/* rx_irq_flags.sv */
// receiver event flags, interrupt, aux pin mapping and clock output
//
// Overview of operation
// - six two-bit aux pin selectors in two registers, all reset to 00
// - clock output divides reference by 1..32, 110 gives rc, 111 off
// - bit 7 set when mode ready, cleared on mode change, resets 1
// - bit 6 set in receive after level, gain, frequency done; clear off rx
// - bit 4 follows pll lock while in synth or receive mode
// - bit 3 set in rx when level over threshold; clear off rx or w1c
// - bit 2 set on either timeout; clear off rx or fifo emptied
// - bit 1 follows intermediate mode entry and exit
// - bit 0 set on sync match in rx; w1c only in continuous mode
// - strength register at 0x24 holds level as minus value over two
// - first timeout after setting*16 bits from rx entry without level event
// - second timeout after setting*16 bits from level event without payload
`timescale 1ns/1ps
module rx_irq_flags #(
  parameter int NUM_AUX  = 6,
  parameter int TO_CNT_W = 12
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire rx_irq_pkg::op_mode_t  op_mode,
  input  wire logic                  xo_running,
  input  wire logic                  pll_locked,
  input  wire logic                  rssi_sampling,
  input  wire logic                  rx_chain_done,
  input  wire logic                  rssi_valid,
  input  wire logic [7:0]            rssi_measured,
  input  wire logic                  intermediate_active,
  input  wire logic                  sync_match,
  input  wire logic                  payload_complete,
  input  wire logic                  fifo_empty,
  input  wire logic                  packet_mode,
  input  wire logic                  bit_tick,
  input  wire logic                  rc_osc_clk,
  input  wire logic [4*NUM_AUX-1:0]  cont_events,
  input  wire logic [4*NUM_AUX-1:0]  pkt_events,
  output logic      [NUM_AUX-1:0]    aux_pin,
  output logic                       clock_out,
  output logic                       rc_osc_en,
  output logic                       irq
);
  // refused at elaboration: the selector layout and the timeout compare are fixed
  if (NUM_AUX != 6) begin : g_bad_aux
    $error("NUM_AUX must be 6");
  end
  if (TO_CNT_W < 12) begin : g_bad_cnt
    $error("TO_CNT_W must be at least 12");
  end

  function automatic logic pick_event(input logic [3:0] ev, input logic [1:0] sel);
    pick_event = ev[sel];
  endfunction : pick_event

  // registers
  logic [7:0]          sel_a_r, sel_a_nxt;
  logic [7:0]          sel_b_r, sel_b_nxt;
  logic [7:0]          flags_r, flags_nxt;
  logic [7:0]          strength_r, strength_nxt;
  logic [7:0]          thresh_r, thresh_nxt;
  logic [7:0]          to1_set_r, to1_set_nxt;
  logic [7:0]          to2_set_r, to2_set_nxt;
  logic [7:0]          status_r, status_nxt;
  logic [7:0]          mask_r, mask_nxt;
  logic [31:0]         prdata_r, prdata_nxt;
  logic                pready_r, pready_nxt;
  logic                pslverr_r, pslverr_nxt;
  logic                irq_r, irq_nxt;
  rx_irq_pkg::op_mode_t mode_prev_r;
  logic                fifo_empty_prev_r;
  logic                to1_arm_r, to1_arm_nxt;
  logic                to2_arm_r, to2_arm_nxt;
  logic [TO_CNT_W-1:0] to1_cnt_r, to1_cnt_nxt;
  logic [TO_CNT_W-1:0] to2_cnt_r, to2_cnt_nxt;
  logic [4:0]          div_cnt_r, div_cnt_nxt;
  logic                div_clk_r, div_clk_nxt;
  logic                rc_en_r, rc_en_nxt;
  logic [NUM_AUX-1:0]  aux_r, aux_nxt;

  // decode helpers
  logic                access, wr_en, rd_en, mapped;
  logic [7:0]          idx;
  logic [7:0]          rd_val;
  logic                in_rx, mode_changed, rx_entry, rx_leave, fifo_emptied;
  logic                mode_ready, level_over, level_event;
  logic                to1_fire, to2_fire;
  logic [15:0]         sel_all;

  assign idx      = paddr[9:2];
  assign access   = psel & penable & pready_r;
  assign wr_en    = access & pwrite;
  assign rd_en    = access & ~pwrite;
  assign in_rx    = (op_mode == rx_irq_pkg::mode_rx);
  assign mode_changed = (op_mode != mode_prev_r);
  assign rx_entry = in_rx & (mode_prev_r != rx_irq_pkg::mode_rx);
  assign rx_leave = ~in_rx;
  assign fifo_emptied = fifo_empty & ~fifo_empty_prev_r;
  assign level_over   = rssi_valid & (rssi_measured > thresh_r);
  assign level_event  = in_rx & level_over & ~flags_r[rx_irq_pkg::BIT_LEVEL_OVER];
  assign sel_all  = {sel_a_r, sel_b_r};

  always_comb begin
    case (op_mode)
      rx_irq_pkg::mode_sleep:   mode_ready = 1'b1;
      rx_irq_pkg::mode_standby: mode_ready = xo_running;
      rx_irq_pkg::mode_synth:   mode_ready = pll_locked;
      rx_irq_pkg::mode_rx:      mode_ready = rssi_sampling;
      default:                  mode_ready = 1'b0;
    endcase
  end

  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (idx)
      rx_irq_pkg::IDX_SIGNAL_STRENGTH: rd_val = strength_r;
      rx_irq_pkg::IDX_AUX_SELECT_A:    rd_val = sel_a_r;
      rx_irq_pkg::IDX_AUX_SELECT_B:    rd_val = sel_b_r & rx_irq_pkg::AUX_B_USED_MASK;
      rx_irq_pkg::IDX_EVENT_FLAGS:     rd_val = flags_r & rx_irq_pkg::FLAGS_USED_MASK;
      rx_irq_pkg::IDX_LEVEL_THRESHOLD: rd_val = thresh_r;
      rx_irq_pkg::IDX_RX_START_TO:     rd_val = to1_set_r;
      rx_irq_pkg::IDX_POST_LEVEL_TO:   rd_val = to2_set_r;
      rx_irq_pkg::IDX_IRQ_STATUS:      rd_val = status_r;
      rx_irq_pkg::IDX_IRQ_MASK:        rd_val = mask_r;
      default:                         mapped = 1'b0;
    endcase
  end

  // timeouts count bit ticks; compare against setting*16
  always_comb begin
    to1_arm_nxt = to1_arm_r;
    to1_cnt_nxt = to1_cnt_r;
    to2_arm_nxt = to2_arm_r;
    to2_cnt_nxt = to2_cnt_r;
    to1_fire    = 1'b0;
    to2_fire    = 1'b0;
    if (rx_entry) begin
      to1_arm_nxt = (to1_set_r != rx_irq_pkg::RST_TIMEOUT);
      to1_cnt_nxt = '0;
      to2_arm_nxt = 1'b0;
    end else if (rx_leave || level_event) begin
      to1_arm_nxt = 1'b0;
    end else if (to1_arm_r && bit_tick) begin
      to1_cnt_nxt = to1_cnt_r + TO_CNT_W'(1);
      if (to1_cnt_nxt == TO_CNT_W'({to1_set_r, 4'h0})) begin
        to1_fire    = 1'b1;
        to1_arm_nxt = 1'b0;
      end
    end
    if (rx_leave || payload_complete) begin
      to2_arm_nxt = 1'b0;
    end else if (level_event) begin
      to2_arm_nxt = (to2_set_r != rx_irq_pkg::RST_TIMEOUT);
      to2_cnt_nxt = '0;
    end else if (to2_arm_r && bit_tick) begin
      to2_cnt_nxt = to2_cnt_r + TO_CNT_W'(1);
      if (to2_cnt_nxt == TO_CNT_W'({to2_set_r, 4'h0})) begin
        to2_fire    = 1'b1;
        to2_arm_nxt = 1'b0;
      end
    end
  end

  // register file, flags and interrupt
  always_comb begin
    sel_a_nxt    = sel_a_r;
    sel_b_nxt    = sel_b_r;
    thresh_nxt   = thresh_r;
    to1_set_nxt  = to1_set_r;
    to2_set_nxt  = to2_set_r;
    mask_nxt     = mask_r;
    strength_nxt = rssi_valid ? rssi_measured : strength_r;
    flags_nxt    = flags_r;
    if (wr_en) begin
      case (idx)
        rx_irq_pkg::IDX_AUX_SELECT_A:    sel_a_nxt = pwdata[7:0];
        rx_irq_pkg::IDX_AUX_SELECT_B:    sel_b_nxt = pwdata[7:0] & rx_irq_pkg::AUX_B_USED_MASK;
        rx_irq_pkg::IDX_LEVEL_THRESHOLD: thresh_nxt = pwdata[7:0];
        rx_irq_pkg::IDX_RX_START_TO:     to1_set_nxt = pwdata[7:0];
        rx_irq_pkg::IDX_POST_LEVEL_TO:   to2_set_nxt = pwdata[7:0];
        rx_irq_pkg::IDX_IRQ_MASK:        mask_nxt = pwdata[7:0];
        default:                         mask_nxt = mask_r;
      endcase
    end
    // bits 3, 2, 0: clears first, sets after so a coincident event wins; for bit 7 a mode change wins
    if (mode_changed) flags_nxt[rx_irq_pkg::BIT_MODE_SETTLED] = 1'b0;
    else if (mode_ready) flags_nxt[rx_irq_pkg::BIT_MODE_SETTLED] = 1'b1;
    flags_nxt[rx_irq_pkg::BIT_RX_READY] = in_rx &
      (flags_r[rx_irq_pkg::BIT_RX_READY] | rx_chain_done);
    flags_nxt[rx_irq_pkg::BIT_SYNTH_LOCK] = pll_locked &
      (in_rx | (op_mode == rx_irq_pkg::mode_synth));
    if (rx_leave) flags_nxt[rx_irq_pkg::BIT_LEVEL_OVER] = 1'b0;
    else if (wr_en && idx == rx_irq_pkg::IDX_EVENT_FLAGS && pwdata[rx_irq_pkg::BIT_LEVEL_OVER])
      flags_nxt[rx_irq_pkg::BIT_LEVEL_OVER] = 1'b0;
    if (in_rx && level_over) flags_nxt[rx_irq_pkg::BIT_LEVEL_OVER] = 1'b1;
    if (rx_leave || fifo_emptied) flags_nxt[rx_irq_pkg::BIT_RX_TIMEOUT] = 1'b0;
    if (to1_fire || to2_fire) flags_nxt[rx_irq_pkg::BIT_RX_TIMEOUT] = 1'b1;
    // intermediate flag mirrors its source; sleep lag comes from the source side
    flags_nxt[rx_irq_pkg::BIT_INTERMEDIATE] = intermediate_active;
    if (rx_leave || fifo_emptied) flags_nxt[rx_irq_pkg::BIT_PATTERN] = 1'b0;
    else if (wr_en && idx == rx_irq_pkg::IDX_EVENT_FLAGS && !packet_mode &&
             pwdata[rx_irq_pkg::BIT_PATTERN])
      flags_nxt[rx_irq_pkg::BIT_PATTERN] = 1'b0;
    if (in_rx && sync_match) flags_nxt[rx_irq_pkg::BIT_PATTERN] = 1'b1;
    flags_nxt = flags_nxt & rx_irq_pkg::FLAGS_USED_MASK;
    // sticky status: rising flag edges; read clears, set wins
    status_nxt = status_r;
    if (rd_en && idx == rx_irq_pkg::IDX_IRQ_STATUS) status_nxt = 8'h00;
    status_nxt = status_nxt | (flags_nxt & ~flags_r);
    irq_nxt     = |(status_nxt & mask_nxt);
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      prdata_nxt  = {24'h00_0000, rd_val};
      pready_nxt  = 1'b1;
      pslverr_nxt = ~mapped;
    end
  end

  // clock output and aux pins
  always_comb begin
    div_cnt_nxt = div_cnt_r + 5'h01;
    div_clk_nxt = 1'b0;
    rc_en_nxt   = (sel_b_r[2:0] == rx_irq_pkg::CLK_CODE_RC);
    if (sel_b_r[2:0] != rx_irq_pkg::CLK_CODE_DIV1 && sel_b_r[2:0] <= rx_irq_pkg::CLK_CODE_MAXD)
      div_clk_nxt = div_cnt_nxt[sel_b_r[2:0] - 3'h1];
  end

  for (genvar g = 0; g < NUM_AUX; g++) begin : g_aux
    always_comb begin
      aux_nxt[g] = packet_mode ?
        pick_event(pkt_events[4*g +: 4], sel_all[15-2*g -: 2]) :
        pick_event(cont_events[4*g +: 4], sel_all[15-2*g -: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a_r           <= rx_irq_pkg::RST_AUX_SELECT_A;
      sel_b_r           <= rx_irq_pkg::RST_AUX_SELECT_B;
      flags_r           <= rx_irq_pkg::RST_EVENT_FLAGS;
      strength_r        <= rx_irq_pkg::RST_SIGNAL_STRENGTH;
      thresh_r          <= rx_irq_pkg::RST_LEVEL_THRESHOLD;
      to1_set_r         <= rx_irq_pkg::RST_TIMEOUT;
      to2_set_r         <= rx_irq_pkg::RST_TIMEOUT;
      status_r          <= 8'h00;
      mask_r            <= 8'h00;
      prdata_r          <= 32'h0000_0000;
      pready_r          <= 1'b0;
      pslverr_r         <= 1'b0;
      irq_r             <= 1'b0;
      mode_prev_r       <= rx_irq_pkg::mode_sleep;
      fifo_empty_prev_r <= 1'b1;
      to1_arm_r         <= 1'b0;
      to2_arm_r         <= 1'b0;
      to1_cnt_r         <= '0;
      to2_cnt_r         <= '0;
      div_cnt_r         <= 5'h00;
      div_clk_r         <= 1'b0;
      rc_en_r           <= 1'b0;
      aux_r             <= '0;
    end else begin
      sel_a_r           <= sel_a_nxt;
      sel_b_r           <= sel_b_nxt;
      flags_r           <= flags_nxt;
      strength_r        <= strength_nxt;
      thresh_r          <= thresh_nxt;
      to1_set_r         <= to1_set_nxt;
      to2_set_r         <= to2_set_nxt;
      status_r          <= status_nxt;
      mask_r            <= mask_nxt;
      prdata_r          <= prdata_nxt;
      pready_r          <= pready_nxt;
      pslverr_r         <= pslverr_nxt;
      irq_r             <= irq_nxt;
      mode_prev_r       <= op_mode;
      fifo_empty_prev_r <= fifo_empty;
      to1_arm_r         <= to1_arm_nxt;
      to2_arm_r         <= to2_arm_nxt;
      to1_cnt_r         <= to1_cnt_nxt;
      to2_cnt_r         <= to2_cnt_nxt;
      div_cnt_r         <= div_cnt_nxt;
      div_clk_r         <= div_clk_nxt;
      rc_en_r           <= rc_en_nxt;
      aux_r             <= aux_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign irq       = irq_r;
  assign aux_pin   = aux_r;
  assign rc_osc_en = rc_en_r;
  // divide-by-one and rc cannot come from a pclk flop; passed through as a mux
  always_comb begin
    case (sel_b_r[2:0])
      rx_irq_pkg::CLK_CODE_DIV1: clock_out = pclk;
      rx_irq_pkg::CLK_CODE_RC:   clock_out = rc_osc_clk & rc_en_r;
      rx_irq_pkg::CLK_CODE_OFF:  clock_out = 1'b0;
      default:                   clock_out = div_clk_r;
    endcase
  end
endmodule : rx_irq_flags

/* rx_irq_pkg.sv */
// shared constants and types for the receiver flag and pin mapping block
package rx_irq_pkg;
  typedef enum logic [1:0] {mode_sleep, mode_standby, mode_synth, mode_rx} op_mode_t;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SIGNAL_STRENGTH = 8'h24;
  localparam logic [7:0] IDX_AUX_SELECT_A    = 8'h25;
  localparam logic [7:0] IDX_AUX_SELECT_B    = 8'h26;
  localparam logic [7:0] IDX_EVENT_FLAGS     = 8'h27;
  localparam logic [7:0] IDX_LEVEL_THRESHOLD = 8'h29;
  localparam logic [7:0] IDX_RX_START_TO     = 8'h2A;
  localparam logic [7:0] IDX_POST_LEVEL_TO   = 8'h2B;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'h41;

  // flag bit positions
  localparam int BIT_MODE_SETTLED = 7;
  localparam int BIT_RX_READY     = 6;
  localparam int BIT_SYNTH_LOCK   = 4;
  localparam int BIT_LEVEL_OVER   = 3;
  localparam int BIT_RX_TIMEOUT   = 2;
  localparam int BIT_INTERMEDIATE = 1;
  localparam int BIT_PATTERN      = 0;
  localparam logic [7:0] FLAGS_USED_MASK = 8'hDF;

  // reset values
  localparam logic [7:0] RST_AUX_SELECT_A    = 8'h00;
  localparam logic [7:0] RST_AUX_SELECT_B    = 8'h07;
  localparam logic [7:0] RST_EVENT_FLAGS     = 8'h80;
  localparam logic [7:0] RST_SIGNAL_STRENGTH = 8'hFF;
  localparam logic [7:0] RST_LEVEL_THRESHOLD = 8'hE4;
  localparam logic [7:0] RST_TIMEOUT         = 8'h00;
  localparam logic [7:0] AUX_B_USED_MASK     = 8'hF7;

  // clock output codes
  localparam logic [2:0] CLK_CODE_DIV1 = 3'h0;
  localparam logic [2:0] CLK_CODE_MAXD = 3'h5;
  localparam logic [2:0] CLK_CODE_RC   = 3'h6;
  localparam logic [2:0] CLK_CODE_OFF  = 3'h7;

  // timeout unit: bit periods per count of a timeout setting
  localparam int TIMEOUT_BITS_PER_STEP = 16;
  localparam int TIMEOUT_SHIFT         = 4;
endpackage : rx_irq_pkg

/* rx_irq_flags_checker_assertions.sv */
// port-level checker for the flag block: bus answer, spare bits, pin routing
`timescale 1ns/1ps
module rx_irq_flags_checker #(
  parameter int NUM_AUX  = 6,
  parameter int TO_CNT_W = 12
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [4*NUM_AUX-1:0] cont_events,
  input wire logic [4*NUM_AUX-1:0] pkt_events,
  input wire logic [NUM_AUX-1:0]   aux_pin,
  input wire logic                 rc_osc_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ack = pready && !pwrite;
  wire same0  = cont_events[3:0] == {4{cont_events[0]}} && pkt_events[3:0] == {4{cont_events[0]}};
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in the cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0000_00)
    else $error("upper read bits not zero");
  a_flag_spare: assert property (rd_ack && paddr[9:2] == 8'h27 |-> !prdata[5])
    else $error("spare flag bit reads one");
  a_map_spare: assert property (rd_ack && paddr[9:2] == 8'h26 |-> !prdata[3])
    else $error("spare mapping bit reads one");
  a_aux_follow: assert property (same0 |=> aux_pin[0] == $past(cont_events[0]))
    else $error("pin 0 does not follow its event");
  a_rc_start: assert property (psel && penable && pready && pwrite && paddr[9:2] == 8'h26
    && pwdata[2:0] == 3'h6 |-> ##[1:2] rc_osc_en)
    else $error("rc oscillator not enabled");
  c_error: cover property (pready && pslverr);
  c_rc: cover property ($rose(rc_osc_en));
  c_pin: cover property ($rose(aux_pin[0]));
endmodule : rx_irq_flags_checker
bind rx_irq_flags rx_irq_flags_checker #(.NUM_AUX(NUM_AUX), .TO_CNT_W(TO_CNT_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .cont_events, .pkt_events, .aux_pin, .rc_osc_en);

/* front_end_model.sv */
// front end stand-in: bit period ticks and an rc oscillator
`timescale 1ns/1ps
module front_end_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rc_osc_en,
  output logic      bit_tick,
  output logic      rc_osc_clk
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 0;
      bit_tick <= 1'b0;
    end else begin
      cnt      <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      bit_tick <= (cnt == TICK_DIV - 1);
    end
  end
  // stands at 0 unless enabled; period unrelated to pclk on purpose
  initial rc_osc_clk = 1'b0;
  always #37 rc_osc_clk = rc_osc_en ? ~rc_osc_clk : 1'b0;
endmodule : front_end_model

/* receiver_irq_flags_pin_mapping_bench.sv */
// self-checking bench for the flag, pin mapping and clock output block
`timescale 1ns/1ps
module receiver_irq_flags_pin_mapping_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic        xo_running, pll_locked, rssi_sampling, rx_chain_done, rssi_valid;
  logic        intermediate_active, sync_match, payload_complete, fifo_empty;
  logic        packet_mode, bit_tick, rc_osc_clk, clock_out, rc_osc_en, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rssi_measured, q;
  logic [23:0] cont_events, pkt_events;
  logic [5:0]  aux_pin;
  int          fails, n_tests, cyc;
  rx_irq_pkg::op_mode_t op_mode;

  rx_irq_flags u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_mode, .xo_running, .pll_locked, .rssi_sampling, .rx_chain_done,
    .rssi_valid, .rssi_measured, .intermediate_active, .sync_match, .payload_complete,
    .fifo_empty, .packet_mode, .bit_tick, .rc_osc_clk, .cont_events, .pkt_events, .aux_pin,
    .clock_out, .rc_osc_en, .irq);
  front_end_model #(.TICK_DIV(4)) u_fe (.pclk, .presetn, .rc_osc_en, .bit_tick, .rc_osc_clk);

  task stop_test;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // holds the request until ready is sampled high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr
  // a few idle cycles first so flags have caught up with the stimulus
  task rd(input logic [7:0] i);
    repeat (3) @(posedge pclk);
    apb(1'b0, i, 8'h00);
  endtask : rd
  task rssi(input logic [7:0] v);
    @(posedge pclk);
    rssi_measured <= v;
    rssi_valid <= 1'b1;
    @(posedge pclk);
    rssi_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : rssi
  task rise;
    logic p;
    p = clock_out;
    @(negedge pclk);
    while (!(clock_out === 1'b1 && p === 1'b0)) begin
      p = clock_out;
      @(negedge pclk);
    end
  endtask : rise

  task t_reset;
    rd(8'h25); chk(q, 8'h00);
    rd(8'h26); chk(q, 8'h07);
    rd(8'h27); chk(q, 8'h80);
    rd(8'h24); chk(q, 8'hFF);
    rd(8'h10); chk({perr, q}, 9'h100);
    chk({rc_osc_en, clock_out}, 2'b00);
  endtask : t_reset
  task t_pins;
    wr(8'h26, 8'hFF); rd(8'h26); chk(q, 8'hF7);
    wr(8'h27, 8'hFF); rd(8'h27); chk(q, 8'h80);
    wr(8'h25, 8'h80); wr(8'h26, 8'h37); rd(8'h25); chk(q, 8'h80);
    cont_events <= 24'h8000_04;
    pkt_events <= 24'h1111_11;
    repeat (3) @(posedge pclk);
    @(negedge pclk); chk(aux_pin, 6'h21);
    @(posedge pclk); packet_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk); chk(aux_pin, 6'h1E);
    cont_events <= 24'h11_111F;
    pkt_events <= 24'h00_000F;
    repeat (3) @(posedge pclk);
    @(negedge pclk); chk(aux_pin[0], 1'b1);
    @(posedge pclk); packet_mode <= 1'b0; intermediate_active <= 1'b1;
    rd(8'h27); chk(q[1], 1'b1);
    @(posedge pclk); intermediate_active <= 1'b0; op_mode <= rx_irq_pkg::mode_rx;
    rd(8'h27); chk(q[1], 1'b0);
    @(posedge pclk); sync_match <= 1'b1;
    @(posedge pclk); sync_match <= 1'b0; packet_mode <= 1'b1;
    wr(8'h27, 8'h01); rd(8'h27); chk(q[0], 1'b1);
    @(posedge pclk); packet_mode <= 1'b0;
    wr(8'h27, 8'h01); rd(8'h27); chk(q[0], 1'b0);
    @(posedge pclk); sync_match <= 1'b1;
    @(posedge pclk); sync_match <= 1'b0; op_mode <= rx_irq_pkg::mode_sleep;
    rd(8'h27); chk(q[0], 1'b0);
  endtask : t_pins
  task automatic t_clock;
    int t0;
    for (int c = 1; c < 6; c++) begin
      wr(8'h26, c[7:0]);
      // first rise may still come from the previous code
      rise;
      rise;
      t0 = cyc;
      rise;
      chk(cyc - t0, 1 << c);
    end
    wr(8'h26, 8'h06); repeat (3) @(negedge pclk); chk(rc_osc_en, 1'b1);
    rise;
    wr(8'h26, 8'h07); repeat (3) @(negedge pclk); chk({rc_osc_en, clock_out}, 2'b00);
    wr(8'h26, 8'h00); @(posedge pclk); #1 chk(clock_out, 1'b1);
    @(negedge pclk); chk(clock_out, 1'b0);
    wr(8'h26, 8'h07);
  endtask : t_clock
  task t_flags;
    @(posedge pclk); {xo_running, pll_locked, rssi_sampling, rx_chain_done} <= 4'hF;
    op_mode <= rx_irq_pkg::mode_rx;
    rd(8'h27); chk(q, 8'hD0);
    wr(8'h41, 8'h08); rssi(8'hF0); chk(irq, 1'b1);
    rd(8'h24); chk(q, 8'hF0);
    rd(8'h27); chk(q, 8'hD8);
    rd(8'h40); repeat (2) @(negedge pclk); chk(irq, 1'b0);
    wr(8'h27, 8'h08); rd(8'h27); chk(q, 8'hD0);
    rssi(8'hE4); rd(8'h27); chk(q, 8'hD0);
    rssi(8'hF0);
    @(posedge pclk); op_mode <= rx_irq_pkg::mode_standby; xo_running <= 1'b0;
    rd(8'h27); chk(q, 8'h00);
    @(posedge pclk); xo_running <= 1'b1;
    rd(8'h27); chk(q, 8'h80);
    @(posedge pclk); op_mode <= rx_irq_pkg::mode_synth; pll_locked <= 1'b0;
    rd(8'h27); chk(q, 8'h00);
    @(posedge pclk); pll_locked <= 1'b1;
    rd(8'h27); chk(q, 8'h90);
  endtask : t_flags
  // one timeout step is 16 ticks of 4 cycles, 64 cycles
  task t_timeouts;
    wr(8'h2A, 8'h01); @(posedge pclk); op_mode <= rx_irq_pkg::mode_rx;
    repeat (45) @(posedge pclk); rd(8'h27); chk(q[2], 1'b0);
    repeat (20) @(posedge pclk); rd(8'h27); chk(q[2], 1'b1);
    @(posedge pclk); op_mode <= rx_irq_pkg::mode_standby;
    rd(8'h27); chk(q[2], 1'b0);
    wr(8'h2A, 8'h00); wr(8'h2B, 8'h01); @(posedge pclk); op_mode <= rx_irq_pkg::mode_rx;
    repeat (80) @(posedge pclk); rd(8'h27); chk(q[2], 1'b0);
    rssi(8'hF0);
    repeat (45) @(posedge pclk); rd(8'h27); chk(q[2], 1'b0);
    repeat (20) @(posedge pclk); rd(8'h27); chk(q[2], 1'b1);
    @(posedge pclk); fifo_empty <= 1'b1;
    rd(8'h27); chk(q[2], 1'b0);
    @(posedge pclk); fifo_empty <= 1'b0;
    wr(8'h27, 8'h08); rssi(8'hF0);
    @(posedge pclk); payload_complete <= 1'b1;
    @(posedge pclk); payload_complete <= 1'b0;
    repeat (80) @(posedge pclk); rd(8'h27); chk(q[2], 1'b0);
  endtask : t_timeouts

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, xo_running, pll_locked, rssi_sampling} = '0;
    {rx_chain_done, rssi_valid, intermediate_active, sync_match} = '0;
    {payload_complete, fifo_empty, packet_mode} = '0;
    {paddr, pwdata, rssi_measured, cont_events, pkt_events} = '0;
    op_mode = rx_irq_pkg::mode_sleep;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_pins;
    t_clock;
    t_flags;
    t_timeouts;
    stop_test;
  end
endmodule : receiver_irq_flags_pin_mapping_bench
